// >>> design/rsq_regs.svh
// Purpose: register map, field positions, reset values and timing counts of the mode sequencer.
// Assumes: 32-bit AHB-Lite words, 50 MHz hclk.
// Notes: signal strength input is 1 dB per LSB, larger is stronger.
// Operation
// RULE1: Enabled collision detector restarts active receiver.
// RULE2: Rise threshold programmable in 1 dB steps.
// RULE3: Sequencer runs only in FSK/OOK mode.
// RULE4: Launch from sleep/standby records initial mode.
// RULE5: Stop bit forces sequencer off immediately.
// RULE6: Host never sets launch and stop together.
// RULE7: Off via low-power selection restores initial mode.
// RULE8: Idle waits only for first-timer event.
// RULE9: Idle select: 0 standby, 1 sleep.
// RULE10: Launch field picks first state.
// RULE11: Low-power target picks off or idle.
// RULE12: Captured initial mode used on every return; the code restores it only when going off from low-power selection.
// RULE13: Idle exit bit: 0 transmit, 1 receive.
// RULE14: Transmit exit bit: 0 low-power, 1 receive.
// RULE15: Any receive timeout is one timeout event.
// RULE16: Packet-held state keeps receiver on.
// RULE17: Receive exit field; second timer forces low-power.
// RULE18: Timeout exit field picks restart/tx/low-power/off.
// RULE19: Packet-held exit field picks next state.
// RULE20: Two chained timers, step times multiplier.
// RULE21: Reset leaves sequencer off, timers stopped.
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

`define RSQ_OFS_CTRL 8'h00
`define RSQ_OFS_TRANS 8'h04
`define RSQ_OFS_TIMER 8'h08
`define RSQ_OFS_RXCFG 8'h0C
`define RSQ_OFS_MODE 8'h10
`define RSQ_OFS_STATUS 8'h14

`define RSQ_CTRL_LAUNCH 0
`define RSQ_CTRL_STOP 1
`define RSQ_CTRL_IDLE_SEL 2
`define RSQ_CTRL_START_LO 3
`define RSQ_CTRL_LP_TGT 5
`define RSQ_CTRL_IDLE_EXIT 6
`define RSQ_CTRL_TX_EXIT 7
`define RSQ_TRANS_RECV_LO 0
`define RSQ_TRANS_TO_LO 3
`define RSQ_TRANS_PKT_LO 5
`define RSQ_TIMER_T1_STEP_LO 0
`define RSQ_TIMER_T2_STEP_LO 2
`define RSQ_TIMER_T1_MULT_LO 8
`define RSQ_TIMER_T2_MULT_LO 16
`define RSQ_RXCFG_COLL_EN 0
`define RSQ_RXCFG_THR_LO 8
`define RSQ_MODE_LO 0
`define RSQ_MODE_LONG_RANGE 7
`define RSQ_STATUS_INIT_SLEEP 4

`define RSQ_RST_THRESHOLD 8'h0A

`define RSQ_CLK_PERIOD_NS 20
`define RSQ_STEP_A_NS 64000
`define RSQ_STEP_B_NS 4100000
`define RSQ_STEP_C_NS 262000000
`define RSQ_STEP_A_CYC (`RSQ_STEP_A_NS / `RSQ_CLK_PERIOD_NS)
`define RSQ_STEP_B_CYC (`RSQ_STEP_B_NS / `RSQ_CLK_PERIOD_NS)
`define RSQ_STEP_C_CYC (`RSQ_STEP_C_NS / `RSQ_CLK_PERIOD_NS)

`endif

// >>> design/rsq_pkg.sv
// Purpose: types shared by the mode sequencer modules.
// Assumes: nothing beyond SystemVerilog packed types.
// Notes: chip mode codes follow the transceiver operating modes.
package rsq_pkg;

  typedef enum logic [2:0] {
    RSQ_SLEEP = 3'h0,
    RSQ_STANDBY = 3'h1,
    RSQ_FSTX = 3'h2,
    RSQ_TX = 3'h3,
    RSQ_FSRX = 3'h4,
    RSQ_RX = 3'h5
  } rsq_mode_t;

  typedef enum logic [3:0] {
    RSQ_OFF = 4'h0,
    RSQ_IDLE = 4'h1,
    RSQ_XMIT = 4'h2,
    RSQ_RECV = 4'h3,
    RSQ_PKT = 4'h4,
    RSQ_LPSEL = 4'h5,
    RSQ_RXTO = 4'h6,
    RSQ_WAITF = 4'h7,
    RSQ_FSWAIT = 4'h8
  } rsq_state_t;

  typedef struct packed {
    logic run;
    logic [23:0] pre;
    logic [7:0] cnt;
    logic fire;
  } rsq_timer_s_t;

  typedef struct packed {
    logic [7:0] base;
    logic fire;
  } rsq_coll_s_t;

  typedef struct packed {
    rsq_state_t st;
    rsq_mode_t mode;
    logic init_sleep;
    logic long_range;
    logic restart;
    logic pend;
    logic pend_wr;
    logic [7:0] pend_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic idle_sel;
    logic [1:0] start_f;
    logic lp_tgt;
    logic idle_exit;
    logic tx_exit;
    logic [2:0] recv_f;
    logic [1:0] to_f;
    logic [2:0] pkt_f;
    logic [1:0] t1_step;
    logic [1:0] t2_step;
    logic [7:0] t1_mult;
    logic [7:0] t2_mult;
    logic coll_en;
    logic [7:0] thr;
  } rsq_top_s_t;

endpackage

// >>> design/rsq_timer.sv
// Purpose: one sequencer period timer, step length times multiplier.
// Assumes: arm is a single-cycle pulse; clear may stay high, as it does while the sequencer is off.
// Notes: step code 0 or multiplier 0 keeps the timer silent.
`timescale 1ns/1ps
`include "rsq_regs.svh"
module rsq_timer import rsq_pkg::*; #(
  parameter int STEP_B_CYC = `RSQ_STEP_B_CYC,
  parameter int STEP_C_CYC = `RSQ_STEP_C_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic arm,
  input wire logic clear,
  input wire logic [1:0] step,
  input wire logic [7:0] mult,
  output logic fire
);

  rsq_timer_s_t s;
  rsq_timer_s_t next_s;
  logic [23:0] lim;

  always_comb begin
    case (step)
      2'h2: lim = 24'(STEP_B_CYC);
      2'h3: lim = 24'(STEP_C_CYC);
      default: lim = 24'(`RSQ_STEP_A_CYC);
    endcase
    next_s = s;
    next_s.fire = 1'b0;
    if (clear) begin
      next_s.run = 1'b0; // RULE21
    end else if (arm) begin
      next_s.run = (step != 2'h0) && (mult != 8'h00); // RULE20
      next_s.pre = 24'h000000;
      next_s.cnt = 8'h01;
    end else if (s.run) begin
      if (s.pre == lim - 24'h000001) begin
        next_s.pre = 24'h000000;
        if (s.cnt >= mult) begin
          next_s.fire = 1'b1; // RULE20
          next_s.run = 1'b0;
        end else begin
          next_s.cnt = s.cnt + 8'h01;
        end
      end else begin
        next_s.pre = s.pre + 24'h000001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign fire = s.fire;

  a_timer_disabled_quiet: // RULE20
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && arm && !clear && step == 2'h0) |=> !s.run)
    else $error("timer armed while its step code is disabled");

endmodule

// >>> design/rsq_collision.sv
// Purpose: detects a sudden rise of received signal strength while receiving.
// Assumes: rssi_level is 1 dB per LSB, larger means stronger.
// Notes: the floor follows falling strength so slow fades never fire.
`timescale 1ns/1ps
module rsq_collision import rsq_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic rx_active,
  input wire logic [7:0] rssi_level,
  input wire logic [7:0] threshold,
  output logic restart
);

  rsq_coll_s_t s;
  rsq_coll_s_t next_s;
  logic [8:0] limit;

  always_comb begin
    limit = {1'b0, s.base} + {1'b0, threshold}; // RULE2
    next_s = s;
    next_s.fire = 1'b0;
    if (!(enable && rx_active)) begin
      next_s.base = rssi_level;
    end else if (threshold != 8'h00 && {1'b0, rssi_level} >= limit) begin
      next_s.fire = 1'b1; // RULE1
      next_s.base = rssi_level;
    end else if (rssi_level < s.base) begin
      next_s.base = rssi_level;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign restart = s.fire;

  a_collision_gated: // RULE1
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.fire) |-> $past(enable && rx_active))
    else $error("collision restart without enable or receiver active");

endmodule

// >>> design/rsq_seq_top.sv
// Purpose: autonomous mode sequencer with AHB-Lite register access.
// Assumes: event inputs are one-cycle pulses synchronous to hclk.
// Notes: every register access takes one wait state; ce low freezes bus and sequencer alike.
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rsq_regs.svh"
module rsq_seq_top import rsq_pkg::*; #(
  parameter int STEP_B_CYC = `RSQ_STEP_B_CYC,
  parameter int STEP_C_CYC = `RSQ_STEP_C_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic fifo_level_irq,
  input wire logic tx_done_irq,
  input wire logic rx_payload_irq,
  input wire logic check_pass_irq,
  input wire logic sync_match_irq,
  input wire logic preamble_detect_irq,
  input wire logic strength_timeout_irq,
  input wire logic preamble_timeout_irq,
  input wire logic sync_timeout_irq,
  input wire logic buffer_drained_irq,
  input wire logic [7:0] rssi_level,
  output logic [2:0] chip_mode,
  output logic rx_restart
);

  rsq_top_s_t s;
  rsq_top_s_t next_s;
  logic first_timer_irq;
  logic second_timer_irq;
  logic coll_hit;
  logic arm1;
  logic tmr_clear;
  logic wr_now;
  logic wr_ctrl;
  logic launch_cmd;
  logic stop_cmd;
  logic receive_timeout_event;
  rsq_mode_t init_mode;

  ////////////////////////////////////////////////////////////////////////////////

  rsq_timer #(.STEP_B_CYC(STEP_B_CYC), .STEP_C_CYC(STEP_C_CYC)) u_first_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .arm(arm1 | second_timer_irq),
    .clear(tmr_clear),
    .step(s.t1_step),
    .mult(s.t1_mult),
    .fire(first_timer_irq)
  );

  rsq_timer #(.STEP_B_CYC(STEP_B_CYC), .STEP_C_CYC(STEP_C_CYC)) u_second_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .arm(first_timer_irq),
    .clear(tmr_clear),
    .step(s.t2_step),
    .mult(s.t2_mult),
    .fire(second_timer_irq)
  );

  rsq_collision u_collision (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .enable(s.coll_en),
    .rx_active(s.st == RSQ_RECV),
    .rssi_level(rssi_level),
    .threshold(s.thr),
    .restart(coll_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;
    arm1 = 1'b0;
    init_mode = s.init_sleep ? RSQ_SLEEP : RSQ_STANDBY;
    receive_timeout_event = strength_timeout_irq | preamble_timeout_irq | sync_timeout_irq; // RULE15
    wr_now = s.pend && s.pend_wr;
    wr_ctrl = wr_now && s.pend_addr == `RSQ_OFS_CTRL;
    launch_cmd = wr_ctrl && hwdata[`RSQ_CTRL_LAUNCH];
    stop_cmd = wr_ctrl && hwdata[`RSQ_CTRL_STOP];

    // The wait state lets read data come from a flop without a combinational path to hrdata.
    if (s.pend) begin
      next_s.pend = 1'b0;
      next_s.ready = 1'b1;
      next_s.rdata = 32'h00000000;
      if (s.pend_wr) begin
        case (s.pend_addr)
          `RSQ_OFS_CTRL: begin
            next_s.idle_sel = hwdata[`RSQ_CTRL_IDLE_SEL];
            next_s.start_f = hwdata[`RSQ_CTRL_START_LO +: 2];
            next_s.lp_tgt = hwdata[`RSQ_CTRL_LP_TGT];
            next_s.idle_exit = hwdata[`RSQ_CTRL_IDLE_EXIT];
            next_s.tx_exit = hwdata[`RSQ_CTRL_TX_EXIT];
          end
          `RSQ_OFS_TRANS: begin
            next_s.recv_f = hwdata[`RSQ_TRANS_RECV_LO +: 3];
            next_s.to_f = hwdata[`RSQ_TRANS_TO_LO +: 2];
            next_s.pkt_f = hwdata[`RSQ_TRANS_PKT_LO +: 3];
          end
          `RSQ_OFS_TIMER: begin
            next_s.t1_step = hwdata[`RSQ_TIMER_T1_STEP_LO +: 2];
            next_s.t2_step = hwdata[`RSQ_TIMER_T2_STEP_LO +: 2];
            next_s.t1_mult = hwdata[`RSQ_TIMER_T1_MULT_LO +: 8];
            next_s.t2_mult = hwdata[`RSQ_TIMER_T2_MULT_LO +: 8];
          end
          `RSQ_OFS_RXCFG: begin
            next_s.coll_en = hwdata[`RSQ_RXCFG_COLL_EN];
            next_s.thr = hwdata[`RSQ_RXCFG_THR_LO +: 8]; // RULE2
          end
          `RSQ_OFS_MODE: begin
            // While running the sequencer owns the chip mode, so host writes are dropped.
            if (s.st == RSQ_OFF) begin
              next_s.mode = rsq_mode_t'(hwdata[`RSQ_MODE_LO +: 3]);
              next_s.long_range = hwdata[`RSQ_MODE_LONG_RANGE];
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (s.pend_addr)
          `RSQ_OFS_CTRL: next_s.rdata = {24'h000000, s.tx_exit, s.idle_exit, s.lp_tgt, s.start_f, s.idle_sel, 2'h0};
          `RSQ_OFS_TRANS: next_s.rdata = {24'h000000, s.pkt_f, s.to_f, s.recv_f};
          `RSQ_OFS_TIMER: next_s.rdata = {8'h00, s.t2_mult, s.t1_mult, 4'h0, s.t2_step, s.t1_step};
          `RSQ_OFS_RXCFG: next_s.rdata = {16'h0000, s.thr, 7'h00, s.coll_en};
          `RSQ_OFS_MODE: next_s.rdata = {24'h000000, s.long_range, 4'h0, s.mode};
          `RSQ_OFS_STATUS: next_s.rdata = {27'h0000000, s.init_sleep, s.st};
          default: next_s.rdata = 32'h00000000;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      next_s.pend = 1'b1;
      next_s.pend_wr = hwrite;
      next_s.pend_addr = haddr[7:0];
      next_s.ready = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stop has priority; the host never pairs it with launch.
    if (stop_cmd) begin
      next_s.st = RSQ_OFF; // RULE5 RULE6
    end else begin
      case (s.st)
        RSQ_OFF: begin
          if (launch_cmd && !s.long_range && (s.mode == RSQ_SLEEP || s.mode == RSQ_STANDBY)) begin // RULE3 RULE4
            next_s.init_sleep = (s.mode == RSQ_SLEEP); // RULE12
            arm1 = 1'b1; // RULE20
            case (next_s.start_f) // RULE10
              2'h0: next_s.st = RSQ_LPSEL;
              2'h1: next_s.st = RSQ_RECV;
              2'h2: next_s.st = RSQ_XMIT;
              default: next_s.st = RSQ_WAITF;
            endcase
          end
        end
        RSQ_WAITF: if (fifo_level_irq) next_s.st = RSQ_XMIT; // RULE10
        RSQ_IDLE: if (first_timer_irq) next_s.st = s.idle_exit ? RSQ_RECV : RSQ_XMIT; // RULE8 RULE13
        RSQ_XMIT: if (tx_done_irq) next_s.st = s.tx_exit ? RSQ_RECV : RSQ_LPSEL; // RULE14
        RSQ_RECV: begin
          if (second_timer_irq) begin
            next_s.st = RSQ_LPSEL; // RULE17
          end else if (receive_timeout_event) begin
            next_s.st = RSQ_RXTO; // RULE15
          end else begin
            case (s.recv_f) // RULE17
              3'h1: if (rx_payload_irq) next_s.st = RSQ_PKT;
              3'h2: if (rx_payload_irq) next_s.st = RSQ_LPSEL;
              3'h3: begin
                if (check_pass_irq) next_s.st = RSQ_PKT;
                else if (rx_payload_irq) next_s.st = RSQ_RXTO;
              end
              3'h4: if (sync_match_irq) next_s.st = RSQ_OFF;
              3'h5: if (preamble_detect_irq) next_s.st = RSQ_OFF;
              default: begin
              end
            endcase
            if (next_s.st == RSQ_RECV && coll_hit) next_s.restart = 1'b1; // RULE1
          end
        end
        RSQ_RXTO: begin
          case (s.to_f) // RULE18
            2'h0: begin
              next_s.st = RSQ_RECV;
              next_s.restart = 1'b1;
            end
            2'h1: next_s.st = RSQ_XMIT;
            2'h2: next_s.st = RSQ_LPSEL;
            default: next_s.st = RSQ_OFF;
          endcase
        end
        RSQ_PKT: begin
          case (s.pkt_f) // RULE19
            3'h0: next_s.st = RSQ_OFF;
            3'h1: if (buffer_drained_irq) next_s.st = RSQ_XMIT;
            3'h2: next_s.st = RSQ_LPSEL;
            3'h3: next_s.st = RSQ_FSWAIT;
            3'h4: next_s.st = RSQ_RECV;
            default: begin
            end
          endcase
        end
        RSQ_FSWAIT: next_s.st = RSQ_RECV; // RULE19
        RSQ_LPSEL: next_s.st = s.lp_tgt ? RSQ_IDLE : RSQ_OFF; // RULE11
        default: next_s.st = RSQ_OFF;
      endcase
    end

    if (next_s.st != s.st) begin
      case (next_s.st)
        RSQ_IDLE: next_s.mode = s.idle_sel ? RSQ_SLEEP : RSQ_STANDBY; // RULE9
        RSQ_XMIT: next_s.mode = RSQ_TX;
        RSQ_RECV: next_s.mode = RSQ_RX;
        RSQ_PKT: next_s.mode = RSQ_RX; // RULE16
        RSQ_FSWAIT: next_s.mode = RSQ_FSRX;
        RSQ_OFF: if (s.st == RSQ_LPSEL) next_s.mode = init_mode; // RULE7 RULE12
        default: begin
        end
      endcase
    end
    tmr_clear = (next_s.st == RSQ_OFF); // RULE21
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0; // RULE21
      s.ready <= 1'b1;
      s.mode <= RSQ_STANDBY;
      s.thr <= `RSQ_RST_THRESHOLD;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign hreadyout = s.ready;
  assign hrdata = s.rdata;
  assign hresp = s.resp;
  assign chip_mode = s.mode;
  assign rx_restart = s.restart;

  ////////////////////////////////////////////////////////////////////////////////

  a_stop_forces_off: // RULE5
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && stop_cmd) |=> s.st == RSQ_OFF)
    else $error("stop did not force the sequencer off");

  a_launch_records_mode: // RULE4
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_OFF && launch_cmd && !stop_cmd && !s.long_range && s.mode == RSQ_SLEEP)
    |=> (s.init_sleep && s.st != RSQ_OFF))
    else $error("launch from sleep not recorded");

  a_long_range_blocks: // RULE3
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_OFF && s.long_range) |=> s.st == RSQ_OFF)
    else $error("sequencer left off in long-range mode");

  a_idle_waits_timer: // RULE8
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_IDLE && !first_timer_irq && !stop_cmd) |=> s.st == RSQ_IDLE)
    else $error("idle left without first-timer event");

  a_lpsel_initial_mode: // RULE7
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_LPSEL && !s.lp_tgt && !stop_cmd)
    |=> (s.st == RSQ_OFF && s.mode == ($past(s.init_sleep) ? RSQ_SLEEP : RSQ_STANDBY)))
    else $error("off from low-power selection lost initial mode");

  a_idle_mode_select: // RULE9
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_LPSEL && s.lp_tgt && !stop_cmd && !wr_ctrl)
    |=> (s.st == RSQ_IDLE && s.mode == ($past(s.idle_sel) ? RSQ_SLEEP : RSQ_STANDBY)))
    else $error("idle entered in wrong low-power mode");

  a_tx_exit_route: // RULE14
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_XMIT && tx_done_irq && !stop_cmd)
    |=> s.st == ($past(s.tx_exit) ? RSQ_RECV : RSQ_LPSEL))
    else $error("transmit exit went to wrong state");

  a_rx_second_timer: // RULE17
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_RECV && second_timer_irq && !stop_cmd) |=> ##1 s.mode != RSQ_RX || s.st != RSQ_RECV)
    else $error("second timer did not leave receive");

  a_rx_timeout_route: // RULE15
  assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && s.st == RSQ_RECV && !second_timer_irq && receive_timeout_event && !stop_cmd) |=> s.st == RSQ_RXTO)
    else $error("receive timeout not taken");

endmodule

// >>> verification/rsq_host_model.sv
// Purpose: host side model that reaches the sequencer registers over AHB-Lite.
// Assumes: one slave, whose hreadyout is the bus ready; single whole-word transfers.
// Notes: waits for ready without a limit of its own, so the bench watchdog ends a hang.
`timescale 1ns/1ps
module rsq_host_model (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  // Callers never ask for launch and stop in one control write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0000_0000, r);
  endtask
endmodule

// >>> verification/tb_radio_mode_sequencer.sv
// Purpose: self-checking bench of the mode sequencer through its register bus and event pins.
// Assumes: step B and C shortened to 20 and 40 cycles; events are one-cycle pulses.
// Notes: state is read back from the status register after each event pulse, or after the second pulse of a pair.
`timescale 1ns/1ps
`include "rsq_regs.svh"
module tb_radio_mode_sequencer import rsq_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_restart;
  logic [31:0] haddr, hwdata, hrdata, st;
  logic [1:0] htrans;
  logic [2:0] hsize, chip_mode;
  logic [9:0] ev;
  logic [7:0] rssi;
  logic [3:0] start_st [4] = '{4'h0, 4'h3, 4'h2, 4'h7};
  int error_cnt, samples_checked, rst_seen, base;
  rsq_host_model host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  rsq_seq_top #(.STEP_B_CYC(20), .STEP_C_CYC(40)) dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fifo_level_irq(ev[0]),
    .tx_done_irq(ev[1]), .rx_payload_irq(ev[2]), .check_pass_irq(ev[3]), .sync_match_irq(ev[4]),
    .preamble_detect_irq(ev[5]), .strength_timeout_irq(ev[6]), .preamble_timeout_irq(ev[7]),
    .sync_timeout_irq(ev[8]), .buffer_drained_irq(ev[9]), .rssi_level(rssi), .chip_mode(chip_mode),
    .rx_restart(rx_restart));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  always @(posedge hclk) if (rx_restart === 1'b1) rst_seen++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input logic [4:0] x);
    host.rd(`RSQ_OFS_STATUS, st);
    chk({27'h0, st[4:0]}, {27'h0, x});
  endtask
  task automatic chk_mode(input logic [2:0] x);
    chk({29'h0, chip_mode}, {29'h0, x});
  endtask
  task automatic pulse(input logic [9:0] e);
    @(posedge hclk);
    ev <= e;
    @(posedge hclk);
    ev <= 10'h000;
  endtask
  // Launches into receive with the given exit fields, fires the events, then stops.
  task automatic rx_case(input logic [7:0] tr, input logic [9:0] e1, e2, input logic [4:0] xs, input int xr);
    base = rst_seen;
    host.wr(`RSQ_OFS_TRANS, {24'h0, tr});
    host.wr(`RSQ_OFS_MODE, 32'h0000_0001);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0029);
    pulse(e1);
    if (e2 != 10'h000) pulse(e2);
    chk_st(xs);
    if (xs == 5'h04) chk_mode(3'h5);
    chk(32'(rst_seen - base), 32'(xr));
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0002);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    ev = 10'h000;
    rssi = 8'h0A;
    error_cnt = 0;
    samples_checked = 0;
    rst_seen = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_st(5'h00);
    chk_mode(3'h1);
    chk({31'h0, hresp}, 32'h0000_0000);
    host.rd(`RSQ_OFS_RXCFG, st);
    chk(st, 32'h0000_0A00);
    host.rd(8'h20, st);
    chk(st, 32'h0000_0000);
    host.wr(`RSQ_OFS_MODE, 32'h0000_0081);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0029);
    chk_st(5'h00);
    // Stop leaves the chip mode where it was, so every launch first sets sleep or standby again.
    for (int s = 0; s < 4; s++) begin
      host.wr(`RSQ_OFS_MODE, 32'h0000_0000);
      host.wr(`RSQ_OFS_CTRL, 32'((s << 3) | 1));
      chk_st({1'b1, start_st[s]});
      if (s == 3) begin
        pulse(10'h001);
        chk_st(5'h12);
      end
      host.wr(`RSQ_OFS_CTRL, 32'h0000_0002);
      chk_st(5'h10);
    end
    for (int m = 0; m < 2; m++) begin
      host.wr(`RSQ_OFS_MODE, 32'(m));
      host.wr(`RSQ_OFS_CTRL, 32'h0000_0011);
      chk_st({m == 0, 4'h2});
      chk_mode(3'h3);
      pulse(10'h002);
      chk_st({m == 0, 4'h0});
      chk_mode(3'(m));
    end
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0091);
    pulse(10'h002);
    chk_st(5'h03);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0002);
    host.wr(`RSQ_OFS_TIMER, 32'h0004_030A);
    host.wr(`RSQ_OFS_MODE, 32'h0000_0001);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0065);
    chk_st(5'h01);
    chk_mode(3'h0);
    repeat (20) @(posedge hclk);
    pulse(10'h3FF);
    chk_st(5'h01);
    repeat (45) @(posedge hclk);
    chk_st(5'h03);
    chk_mode(3'h5);
    repeat (75) @(posedge hclk);
    chk_st(5'h01);
    repeat (60) @(posedge hclk);
    chk_st(5'h03);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0002);
    host.wr(`RSQ_OFS_MODE, 32'h0000_0001);
    host.wr(`RSQ_OFS_TIMER, 32'h0000_0103);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0021);
    chk_st(5'h01);
    chk_mode(3'h1);
    repeat (40) @(posedge hclk);
    chk_st(5'h02);
    chk_mode(3'h3);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0002);
    host.wr(`RSQ_OFS_TIMER, 32'h0000_0000);
    rx_case(8'hA1, 10'h004, 10'h000, 5'h04, 0);
    rx_case(8'hA2, 10'h004, 10'h000, 5'h01, 0);
    rx_case(8'hA3, 10'h00C, 10'h000, 5'h04, 0);
    rx_case(8'hAB, 10'h004, 10'h000, 5'h02, 0);
    rx_case(8'hA4, 10'h010, 10'h000, 5'h00, 0);
    rx_case(8'hA5, 10'h020, 10'h000, 5'h00, 0);
    rx_case(8'hB8, 10'h040, 10'h000, 5'h00, 0);
    rx_case(8'hB8, 10'h080, 10'h000, 5'h00, 0);
    rx_case(8'hB8, 10'h100, 10'h000, 5'h00, 0);
    rx_case(8'hB0, 10'h040, 10'h000, 5'h01, 0);
    rx_case(8'hA0, 10'h040, 10'h000, 5'h03, 1);
    rx_case(8'h01, 10'h004, 10'h000, 5'h00, 0);
    rx_case(8'h21, 10'h004, 10'h200, 5'h02, 0);
    rx_case(8'h41, 10'h004, 10'h000, 5'h01, 0);
    rx_case(8'h61, 10'h004, 10'h000, 5'h03, 0);
    rx_case(8'h81, 10'h004, 10'h000, 5'h03, 0);
    host.wr(`RSQ_OFS_RXCFG, 32'h0000_0501);
    host.wr(`RSQ_OFS_TRANS, 32'h0000_0000);
    host.wr(`RSQ_OFS_MODE, 32'h0000_0001);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0029);
    repeat (5) @(posedge hclk);
    base = rst_seen;
    rssi <= 8'h0E;
    repeat (6) @(posedge hclk);
    chk(32'(rst_seen - base), 32'h0);
    rssi <= 8'h14;
    repeat (6) @(posedge hclk);
    chk(32'(rst_seen - base), 32'h1);
    host.wr(`RSQ_OFS_RXCFG, 32'h0000_0500);
    rssi <= 8'h00;
    repeat (4) @(posedge hclk);
    base = rst_seen;
    rssi <= 8'h40;
    repeat (6) @(posedge hclk);
    chk(32'(rst_seen - base), 32'h0);
    host.wr(`RSQ_OFS_CTRL, 32'h0000_0002);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    end_sim();
  end
endmodule
